// ===== core/pcr_config_regs.sv
// configuration register bank of the flat-panel controller
//
// Operation
// [R1] every register is reached through the serial link's request port and each request is answered.
// [R2] registers sit at fixed word offsets 0x400 to 0x43c in one address space.
// [R3] the memory control register picks the frame buffer type and resets to 0x1ef80008.
// [R4] writing the dither RAM pointer loads the dither address counter.
// [R5] each dither window read or write moves one word at the counter, then adds one to it.
// [R6] the host loads the dither pointer before using the dither window.
// [R7] while signature capture is on, the CRC result is stored in the signature register.
// [R8] blue, green and red each have a 15-bit modulation seed register.
// [R9] the 32 by 64-bit modulation memory is reached through an index and a data register.
// [R10] the identification register is read-only and returns a fixed id; writes do nothing.
// [R11] the pin data register reports pin levels and status.
// [R12] the pin control register sets direction and normal or weak pull mode per pin.
// [R13] timing, power, dither, seed, modulation and dither RAM registers reset to zero.
// [R14] a weak pull acts only when the pin's mode bit is one and it is an output.
// [R15] registers are 32-bit words; reserved bits read zero and ignore writes.
`default_nettype none
module pcr_config_regs #(
    parameter int DITHER_DEPTH = pcr_pkg::DITHER_DEPTH,
    // arbitrary identification value
    parameter logic [31:0] ID_VALUE = 32'h5a5a_0001
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire pcr_pkg::pcr_req_type req,
    output logic ack,
    output logic [31:0] rdata,
    output pcr_pkg::pcr_cfg_type cfg,
    input wire logic sig_enable,
    input wire logic sig_valid,
    input wire logic [31:0] sig_value,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pull_up,
    output logic [7:0] pin_pull_down
);
    localparam int DA = $clog2(DITHER_DEPTH);

    logic [31:0] timing_one_q;
    logic [31:0] timing_two_q;
    logic [31:0] power_q;
    logic [31:0] dither_frc_q;
    logic [14:0] blue_seed_q;
    logic [14:0] green_seed_q;
    logic [14:0] red_seed_q;
    logic [5:0] mod_idx_q;
    logic [31:0] mem_ctl_q;
    logic [DA-1:0] dram_ptr_q;
    logic [31:0] sig_q;
    logic [7:0] pin_data_q;
    logic [23:0] pin_ctl_q;
    logic [63:0] mod_mem [pcr_pkg::MOD_ENTRIES];
    logic [31:0] dram [DITHER_DEPTH];
    logic [31:0] rdata_d;
    logic [31:0] rd_word;
    logic [7:0] pin_s;

    pcr_sync #(
        .W(pcr_pkg::GPIO_N)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(pin_in),
        .sync_out(pin_s)
    );

    // request decode
    wire logic wr = req.valid && req.write;
    wire logic rd = req.valid && !req.write;
    wire logic hit_t1 = req.addr == pcr_pkg::OFF_TIMING_ONE;
    wire logic hit_t2 = req.addr == pcr_pkg::OFF_TIMING_TWO;
    wire logic hit_pw = req.addr == pcr_pkg::OFF_POWER;
    wire logic hit_df = req.addr == pcr_pkg::OFF_DITHER_FRC;
    wire logic hit_bs = req.addr == pcr_pkg::OFF_BLUE_SEED;
    wire logic hit_gs = req.addr == pcr_pkg::OFF_GREEN_SEED;
    wire logic hit_rs = req.addr == pcr_pkg::OFF_RED_SEED;
    wire logic hit_fi = req.addr == pcr_pkg::OFF_MOD_INDEX;
    wire logic hit_fd = req.addr == pcr_pkg::OFF_MOD_DATA;
    wire logic hit_mc = req.addr == pcr_pkg::OFF_MEM_CTL;
    wire logic hit_dp = req.addr == pcr_pkg::OFF_DRAM_PTR;
    wire logic hit_dw = req.addr == pcr_pkg::OFF_DRAM_WIN;
    wire logic hit_sg = req.addr == pcr_pkg::OFF_SIGNATURE;
    wire logic hit_id = req.addr == pcr_pkg::OFF_PART_ID;
    wire logic hit_pd = req.addr == pcr_pkg::OFF_PIN_DATA;
    wire logic hit_pc = req.addr == pcr_pkg::OFF_PIN_CTL;
    wire logic mapped = hit_t1 | hit_t2 | hit_pw | hit_df | hit_bs | hit_gs | hit_rs | hit_fi
        | hit_fd | hit_mc | hit_dp | hit_dw | hit_sg | hit_id | hit_pd | hit_pc;

    wire logic dw_access = req.valid && hit_dw;
    wire logic [DA-1:0] dram_ptr_inc = dram_ptr_q + 1'b1;
    wire logic sig_capture = sig_enable && sig_valid;

    // modulation entry select: index bit 0 picks the 32-bit half
    wire logic [4:0] mod_entry = mod_idx_q[5:1];
    wire logic mod_high = mod_idx_q[0];
    wire logic [63:0] mod_word = mod_mem[mod_entry];
    wire logic [31:0] mod_half = mod_high ? mod_word[63:32] : mod_word[31:0];

    // pin views
    wire logic [7:0] pin_type = pin_ctl_q[pcr_pkg::PIN_TYPE_LSB +: 8];
    wire logic [7:0] pin_mode = pin_ctl_q[pcr_pkg::PIN_MODE_LSB +: 8];
    wire logic [7:0] pin_pupd = pin_ctl_q[pcr_pkg::PIN_PUPD_LSB +: 8];
    wire logic [7:0] pin_level = (pin_data_q & pin_type) | (pin_s & ~pin_type);
    wire logic [7:0] pin_data_d = (req.wdata[7:0] & pin_type) | (pin_data_q & ~pin_type);
    wire logic [7:0] pull_on = pin_mode & pin_type; // R14

    // read mux; narrow registers pad with zero
    always_comb begin
        rd_word = pcr_pkg::RST_ZERO;
        case (1'b1)
            hit_t1: rd_word = timing_one_q;
            hit_t2: rd_word = timing_two_q;
            hit_pw: rd_word = power_q;
            hit_df: rd_word = dither_frc_q;
            hit_bs: rd_word = {17'h0, blue_seed_q}; // R15
            hit_gs: rd_word = {17'h0, green_seed_q};
            hit_rs: rd_word = {17'h0, red_seed_q};
            hit_fi: rd_word = {26'h0, mod_idx_q};
            hit_fd: rd_word = mod_half; // R9
            hit_mc: rd_word = mem_ctl_q;
            hit_dp: rd_word = {{(32 - DA){1'b0}}, dram_ptr_q};
            hit_dw: rd_word = dram[dram_ptr_q]; // R5
            hit_sg: rd_word = sig_q;
            hit_id: rd_word = ID_VALUE; // R10
            hit_pd: rd_word = {16'h0, pin_s, pin_level}; // R11
            hit_pc: rd_word = {8'h0, pin_ctl_q};
            default: rd_word = pcr_pkg::RST_ZERO;
        endcase
    end

    // unmapped reads answer with zero
    assign rdata_d = (rd && mapped) ? rd_word : pcr_pkg::RST_ZERO; // R2

    // answer one cycle after every request
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            rdata <= pcr_pkg::RST_ZERO;
        end else begin
            ack <= req.valid; // R1
            rdata <= rdata_d;
        end
    end

    // plain control words
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timing_one_q <= pcr_pkg::RST_ZERO; // R13
            timing_two_q <= pcr_pkg::RST_ZERO;
            power_q <= pcr_pkg::RST_ZERO;
            dither_frc_q <= pcr_pkg::RST_ZERO;
            mem_ctl_q <= pcr_pkg::RST_MEM_CTL; // R3
        end else begin
            if (wr && hit_t1) timing_one_q <= req.wdata;
            if (wr && hit_t2) timing_two_q <= req.wdata;
            if (wr && hit_pw) power_q <= req.wdata;
            if (wr && hit_df) dither_frc_q <= req.wdata;
            if (wr && hit_mc) mem_ctl_q <= req.wdata; // R3
        end
    end

    // seeds and modulation index keep only their low bits
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blue_seed_q <= 15'h0000; // R13
            green_seed_q <= 15'h0000;
            red_seed_q <= 15'h0000;
            mod_idx_q <= 6'h00;
        end else begin
            if (wr && hit_bs) blue_seed_q <= req.wdata[14:0]; // R8
            if (wr && hit_gs) green_seed_q <= req.wdata[14:0];
            if (wr && hit_rs) red_seed_q <= req.wdata[14:0];
            if (wr && hit_fi) mod_idx_q <= req.wdata[5:0]; // R9
        end
    end

    // modulation memory cleared at reset so the data register reads zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < pcr_pkg::MOD_ENTRIES; i++) begin
                mod_mem[i] <= 64'h0; // R13
            end
        end else if (wr && hit_fd) begin
            if (mod_high) begin
                mod_mem[mod_entry][63:32] <= req.wdata; // R9
            end else begin
                mod_mem[mod_entry][31:0] <= req.wdata;
            end
        end
    end

    // dither address counter; a pointer write in the same cycle is impossible
    // since one request is taken per cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dram_ptr_q <= '0; // R13
        end else if (wr && hit_dp) begin
            dram_ptr_q <= req.wdata[DA-1:0]; // R4
        end else if (dw_access) begin
            dram_ptr_q <= dram_ptr_inc; // R5
        end
    end

    // dither storage cleared at reset so the window reads zero; costs the memory macro
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DITHER_DEPTH; i++) begin
                dram[i] <= pcr_pkg::RST_ZERO; // R13
            end
        end else if (wr && hit_dw) begin
            dram[dram_ptr_q] <= req.wdata; // R5
        end
    end

    // hardware capture wins over a host write in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sig_q <= pcr_pkg::RST_ZERO;
        end else if (sig_capture) begin
            sig_q <= sig_value; // R7
        end else if (wr && hit_sg) begin
            sig_q <= req.wdata;
        end
    end

    // pin registers; input pins ignore data writes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_data_q <= pcr_pkg::RST_PIN_DATA;
            pin_ctl_q <= pcr_pkg::RST_PIN_CTL;
        end else begin
            if (wr && hit_pd) pin_data_q <= pin_data_d; // R11
            if (wr && hit_pc) pin_ctl_q <= req.wdata[23:0]; // R12 R15
        end
    end

    // pin drive, one cycle behind the control word; strong drive only in normal mode
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
            pin_pull_up <= 8'h00;
            pin_pull_down <= 8'h00;
        end else begin
            pin_out <= pin_data_q;
            pin_oe <= pin_type & ~pin_mode; // R12
            pin_pull_up <= pull_on & pin_pupd; // R14
            pin_pull_down <= pull_on & ~pin_pupd;
        end
    end

    assign cfg.timing_one = timing_one_q;
    assign cfg.timing_two = timing_two_q;
    assign cfg.power = power_q;
    assign cfg.dither_frc = dither_frc_q;
    assign cfg.blue_seed = blue_seed_q;
    assign cfg.green_seed = green_seed_q;
    assign cfg.red_seed = red_seed_q;
    assign cfg.mem_ctl = mem_ctl_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    chk_ack_follows_req: assert property ( // R1
        req.valid |=> ack ##1 (ack == $past(req.valid)))
        else $error("request not answered next cycle");

    chk_unmapped_read_zero: assert property ( // R2
        (rd && !mapped) |=> (ack && rdata == 32'h0))
        else $error("unmapped read not zero");

    chk_ptr_load_value: assert property ( // R4
        (wr && hit_dp) |=> (dram_ptr_q == $past(req.wdata[DA-1:0])))
        else $error("dither pointer not loaded");

    chk_window_advance: assert property ( // R5
        dw_access |=> (dram_ptr_q == $past(dram_ptr_inc)))
        else $error("dither pointer did not advance");

    chk_window_write_read: assert property ( // R5
        (wr && hit_dw) ##1 !req.valid ##1 (rd && hit_dp)
        |=> (rdata[DA-1:0] == DA'($past(dram_ptr_q, 3) + 1'b1)))
        else $error("pointer readback wrong after window write");

    chk_sig_capture: assert property ( // R7
        sig_capture |=> (sig_q == $past(sig_value)))
        else $error("signature not captured");

    chk_seed_upper_zero: assert property ( // R8
        (rd && (hit_bs || hit_gs || hit_rs)) |=> (rdata[31:15] == 17'h0))
        else $error("seed upper bits not zero");

    chk_id_readonly: assert property ( // R10
        (rd && hit_id) |=> (rdata == ID_VALUE))
        else $error("id register wrong");

    chk_pull_gating: assert property ( // R14
        ((pin_pull_up | pin_pull_down) & ~$past(pull_on)) == 8'h00)
        else $error("weak pull without mode and output");

    chk_pull_exclusive: assert property ( // R12
        ((pin_pull_up & pin_pull_down) | (pin_oe & (pin_pull_up | pin_pull_down))) == 8'h00)
        else $error("pin drive modes overlap");

    chk_mem_ctl_write: assert property ( // R3
        (wr && hit_mc) |=> (mem_ctl_q == $past(req.wdata)))
        else $error("memory control write lost");

    chk_window_write_lands: assert property ( // R5
        (wr && hit_dw) |=> (dram[$past(dram_ptr_q)] == $past(req.wdata)))
        else $error("dither window write lost");

    chk_seed_write: assert property ( // R8
        (wr && hit_bs) |=> (blue_seed_q == $past(req.wdata[14:0])))
        else $error("seed write lost");

    chk_mod_half_write: assert property ( // R9
        (wr && hit_fd && !mod_high) |=> (mod_mem[$past(mod_entry)][31:0] == $past(req.wdata)))
        else $error("modulation low half write lost");

    chk_pin_input_kept: assert property ( // R11
        (wr && hit_pd) |=> (((pin_data_q ^ $past(pin_data_q)) & ~$past(pin_type)) == 8'h00))
        else $error("input pin data overwritten");

    chk_ctl_reserved_zero: assert property ( // R15
        (rd && hit_pc) |=> (rdata[31:24] == 8'h00))
        else $error("pin control reserved bits not zero");

    cov_window_burst: cover property (
        (wr && hit_dp) ##1 dw_access [*3]);

    cov_sig_over_write: cover property (
        sig_capture && wr && hit_sg);

    cov_weak_pull: cover property (
        pin_pull_up != 8'h00 ##1 pin_pull_down != 8'h00);

    cov_mod_high_write: cover property (
        wr && hit_fd && mod_high);

    cov_window_read: cover property (
        (rd && hit_dw) ##1 ack);
endmodule : pcr_config_regs
`default_nettype wire

// ===== core/pcr_pkg.sv
// package: register map, reset values and carrier types of the panel config bank
`default_nettype none
package pcr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int SEED_W = 15;
    localparam int MOD_ENTRIES = 32;
    localparam int MOD_W = 64;
    localparam int MOD_IDX_W = 6;
    localparam int GPIO_N = 8;
    localparam int DITHER_DEPTH = 64;

    localparam logic [11:0] OFF_TIMING_ONE = 12'h400;
    localparam logic [11:0] OFF_TIMING_TWO = 12'h404;
    localparam logic [11:0] OFF_POWER = 12'h408;
    localparam logic [11:0] OFF_DITHER_FRC = 12'h40c;
    localparam logic [11:0] OFF_BLUE_SEED = 12'h410;
    localparam logic [11:0] OFF_GREEN_SEED = 12'h414;
    localparam logic [11:0] OFF_MOD_INDEX = 12'h418;
    localparam logic [11:0] OFF_MOD_DATA = 12'h41c;
    localparam logic [11:0] OFF_MEM_CTL = 12'h420;
    localparam logic [11:0] OFF_DRAM_PTR = 12'h424;
    localparam logic [11:0] OFF_DRAM_WIN = 12'h428;
    localparam logic [11:0] OFF_SIGNATURE = 12'h42c;
    localparam logic [11:0] OFF_PART_ID = 12'h430;
    localparam logic [11:0] OFF_PIN_DATA = 12'h434;
    localparam logic [11:0] OFF_PIN_CTL = 12'h438;
    localparam logic [11:0] OFF_RED_SEED = 12'h43c;

    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_MEM_CTL = 32'h1ef8_0008;
    localparam logic [7:0] RST_PIN_DATA = 8'h00;
    localparam logic [23:0] RST_PIN_CTL = 24'h00_0000;

    localparam int PIN_TYPE_LSB = 0;
    localparam int PIN_MODE_LSB = 8;
    localparam int PIN_PUPD_LSB = 16;
    localparam int PIN_STS_LSB = 8;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } pcr_req_type;

    typedef struct packed {
        logic [31:0] timing_one;
        logic [31:0] timing_two;
        logic [31:0] power;
        logic [31:0] dither_frc;
        logic [14:0] blue_seed;
        logic [14:0] green_seed;
        logic [14:0] red_seed;
        logic [31:0] mem_ctl;
    } pcr_cfg_type;
endpackage : pcr_pkg
`default_nettype wire

// ===== core/pcr_sync.sv
// two-flop synchroniser for pin levels
`default_nettype none
module pcr_sync #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // meta_q is read only by the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : pcr_sync
`default_nettype wire

// ===== bench/pcr_host_model.sv
// host-side model that issues requests on the register port
`default_nettype none
module pcr_host_model (
    input wire logic core_clk,
    output pcr_pkg::pcr_req_type req,
    input wire logic ack,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // valid is a one-cycle pulse, so it drops at the answer's falling edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic ok);
        ok = 1'b0;
        rd = 32'h0000_0000;
        @(negedge core_clk);
        req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(negedge core_clk);
        // released fields show the inverse, not the stale value
        req <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
        for (int i = 0; i < 4; i++) begin
            if (ack === 1'b1) begin
                rd = rdata;
                ok = 1'b1;
                break;
            end
            @(negedge core_clk);
        end
    endtask : xfer
endmodule : pcr_host_model
`default_nettype wire

// ===== bench/pcr_config_regs_bench.sv
// self-checking bench of the panel config register bank
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module pcr_config_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // arbitrary identification value
    localparam logic [31:0] ID_TEST = 32'h1234_5678;
    localparam int DEPTH = pcr_pkg::DITHER_DEPTH;

    logic core_clk, rst_n, ack, sig_enable, sig_valid;
    logic [31:0] rdata, sig_value;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down;
    pcr_pkg::pcr_req_type req;
    pcr_pkg::pcr_cfg_type cfg;
    int n_errors = 0;
    int n_checks = 0;

    pcr_config_regs #(.DITHER_DEPTH(DEPTH), .ID_VALUE(ID_TEST)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .req(req), .ack(ack), .rdata(rdata), .cfg(cfg),
        .sig_enable(sig_enable), .sig_valid(sig_valid), .sig_value(sig_value), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down));

    pcr_host_model host (.core_clk(core_clk), .req(req), .ack(ack), .rdata(rdata));

    always #10 core_clk = ~core_clk;

    task automatic test_done;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // a missing answer ends the run rather than hanging it
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        logic ok;
        host.xfer(w, a, d, r, ok);
        if (ok !== 1'b1) begin
            n_errors++;
            $display("ERROR t=%0t no answer addr=%h", $time, a);
            test_done();
        end
    endtask : acc

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        acc(1'b0, a, 32'h0000_0000, r);
        `CHK(r, e)
    endtask : rchk

    task automatic t_reset;
        logic [11:0] a;
        for (int i = 0; i < 16; i++) begin
            a = 12'h400 + (12'(i) << 2);
            rchk(a, a == 12'h420 ? 32'h1ef8_0008 : a == 12'h430 ? ID_TEST : 32'h0000_0000);
        end
        `CHK(cfg.mem_ctl, 32'h1ef8_0008)
        `CHK({pin_oe, pin_pull_up, pin_pull_down}, 24'h00_0000)
    endtask : t_reset

    task automatic t_regs;
        logic [11:0] offs [7] = '{12'h400, 12'h404, 12'h408, 12'h40c, 12'h410, 12'h414, 12'h43c};
        logic [31:0] r;
        for (int i = 0; i < 7; i++) begin
            acc(1'b1, offs[i], 32'hffff_ffff, r);
            rchk(offs[i], i < 4 ? 32'hffff_ffff : 32'h0000_7fff);
        end
        `CHK({cfg.blue_seed, cfg.green_seed, cfg.red_seed}, 45'h1fff_ffff_ffff)
        `CHK(cfg.timing_two, 32'hffff_ffff)
        `CHK({cfg.timing_one, cfg.power, cfg.dither_frc}, {3{32'hffff_ffff}})
        acc(1'b1, 12'h430, 32'h0f0f_0f0f, r);
        rchk(12'h430, ID_TEST);
        acc(1'b1, 12'h440, 32'hffff_ffff, r);
        rchk(12'h440, 32'h0000_0000);
        rchk(12'h402, 32'h0000_0000);
        acc(1'b1, 12'h418, 32'hffff_ffff, r);
        rchk(12'h418, 32'h0000_003f);
        acc(1'b1, 12'h420, 32'h0000_0000, r);
        rchk(12'h420, 32'h0000_0000);
        `CHK(cfg.mem_ctl, 32'h0000_0000)
    endtask : t_regs

    task automatic t_mod;
        logic [31:0] r;
        for (int k = 0; k < 3; k++) begin
            acc(1'b1, 12'h418, 32'(4 + k), r);
            acc(1'b1, 12'h41c, 32'h1111_0000 * 32'(k + 1) + 32'(k), r);
        end
        for (int k = 0; k < 3; k++) begin
            acc(1'b1, 12'h418, 32'(4 + k), r);
            rchk(12'h41c, 32'h1111_0000 * 32'(k + 1) + 32'(k));
        end
    endtask : t_mod

    // start near the top so the counter must wrap
    task automatic t_dither;
        logic [31:0] r;
        acc(1'b1, 12'h424, 32'(DEPTH - 2), r);
        for (int k = 0; k < 3; k++) acc(1'b1, 12'h428, 32'hd000_0000 + 32'(k), r);
        rchk(12'h424, 32'h0000_0001);
        acc(1'b1, 12'h424, 32'(DEPTH - 2), r);
        for (int k = 0; k < 3; k++) rchk(12'h428, 32'hd000_0000 + 32'(k));
        rchk(12'h424, 32'h0000_0001);
    endtask : t_dither

    task automatic t_sig;
        for (int en = 0; en < 2; en++) begin
            @(negedge core_clk);
            sig_enable = en[0];
            sig_value = 32'hc0de_0001 + 32'(en);
            sig_valid = 1'b1;
            @(negedge core_clk);
            sig_valid = 1'b0;
            rchk(12'h42c, en == 1 ? 32'hc0de_0002 : 32'h0000_0000);
        end
    endtask : t_sig

    // pin 2 has pull select without mode, pin 4 has mode without output
    task automatic t_pins;
        logic [31:0] r;
        pin_in = 8'ha5;
        acc(1'b1, 12'h438, 32'h0005_130f, r);
        acc(1'b1, 12'h434, 32'h0000_00ff, r);
        @(negedge core_clk);
        `CHK(pin_oe, 8'h0c)
        `CHK(pin_pull_up, 8'h01)
        `CHK(pin_pull_down, 8'h02)
        `CHK(pin_out, 8'h0f)
        rchk(12'h438, 32'h0005_130f);
        rchk(12'h434, 32'h0000_a5af);
    endtask : t_pins

    // reset in mid-run must bring every register back; pins quiet so status reads zero
    task automatic t_rerun;
        @(negedge core_clk);
        pin_in = 8'h00;
        rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
    endtask : t_rerun

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        sig_enable = 1'b0;
        sig_valid = 1'b0;
        sig_value = 32'h0000_0000;
        pin_in = 8'h00;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_mod();
        t_dither();
        t_sig();
        t_pins();
        t_rerun();
        test_done();
    end
endmodule : pcr_config_regs_bench
`default_nettype wire
